// ### test/tb_wdo_top.sv
// Self-checking bench for the watchdog top.
`timescale 1ns/1ps
module tb_wdo_top;
  import wdo_pkg::*;
  // ----------------------------------------
  // Signals, tasks and test sequence
  // ----------------------------------------
  logic aclk, aresetn, external_reset_pin_n, power_up, rc_osc_tick, rc_clock_enable_bit;
  logic sys_osc_run, internal_rc_osc_run, second_osc_pin, wake, chip_reset, warm_reset;
  logic charge_pump_output_sel, timeout_flag, power_down_flag;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wdo_cfg_t cfg;
  wdo_evt_t evt;
  wdo_mode_t mode;
  logic [33:0] eq[$], mq[$], e, m;
  logic [1:0] bq[$];
  int miscompares = 0, checks = 0, cyc = 0, n, i;
  integer seed = 32'hd217e8f3;

  wdo_top u_wdo_top (.*);

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  task give_verdict;
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task chk(input logic [33:0] s, input logic [33:0] x);
    checks++;
    if (s !== x) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, x);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    bq.push_back(r);
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw || w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 0;
      if (s_axi_wready) w = 0;
      if (!aw) s_axi_awvalid <= 0;
      if (!w) s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 0;
  endtask : wr

  task rd(input logic [11:0] a, input logic [1:0] r, input logic [31:0] d, input logic [31:0] k);
    eq.push_back({r, d});
    mq.push_back({2'h3, k});
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 0;
  endtask : rd

  task ev(input wdo_evt_t x);
    evt <= x;
    @(posedge aclk);
    evt <= '0;
    @(posedge aclk);
  endtask : ev

  task tk(input int t);
    rc_osc_tick <= 1;
    repeat (t) @(posedge aclk);
    rc_osc_tick <= 0;
  endtask : tk

  // Ticks run until the pulse shows; stopping then keeps later counts predictable.
  task run_to(input logic warm);
    rc_osc_tick <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(warm ? warm_reset : chip_reset) && n < 9000);
    rc_osc_tick <= 0;
  endtask : run_to

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = eq.pop_front();
      m = mq.pop_front();
      chk({s_axi_rresp, s_axi_rdata} & m, e & m);
    end
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 50000) begin
      miscompares++;
      give_verdict;
    end
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {power_up, rc_osc_tick, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {external_reset_pin_n, rc_clock_enable_bit} = 2'h3;
    s_axi_wstrb = 4'hf;
    evt = '0;
    cfg = 7'h71;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(12'h070, 2'h0, 32'h8, 32'hc);
    for (i = 0; i < 16; i++) begin
      n = $random(seed);
      wr(12'h070, {n[31:4], i[3:0]}, 2'h0);
      rd(12'h070, 2'h0, i, 32'hffffff0f);
      chk(charge_pump_output_sel, i[1:0] != 2'h2);
      chk(internal_rc_osc_run, i[3:2] != 2'h1);
    end
    wr(12'h070, 32'h9, 2'h0);
    rd(12'h100, 2'h2, 32'h0, 32'h0);
    ev(8'h80);
    tk(100);
    wr(12'h074, 32'hff, 2'h0);
    rd(12'h074, 2'h0, 32'h3, '1);
    cfg.paired_clear <= 1;
    ev(8'h40);
    rd(12'h074, 2'h0, 32'h3, '1);
    ev(8'h20);
    rd(12'h074, 2'h0, 32'h0, '1);
    cfg.paired_clear <= 0;
    tk(28);
    rd(12'h074, 2'h0, 32'h0, '1);
    tk(100);
    external_reset_pin_n <= 0;
    @(posedge aclk);
    external_reset_pin_n <= 1;
    @(posedge aclk);
    rd(12'h074, 2'h0, 32'h0, '1);
    ev(8'h80);
    run_to(0);
    chk(n >= 8192 && n <= 8194, 1);
    rd(12'h080, 2'h0, 32'h20, 32'h30);
    power_up <= 1;
    @(posedge aclk);
    power_up <= 0;
    @(posedge aclk);
    rd(12'h080, 2'h0, 32'h0, 32'h30);
    ev(8'h08);
    chk(mode, WDO_IDLE);
    chk({sys_osc_run, internal_rc_osc_run}, 2'h1);
    run_to(1);
    chk({n < 9000, chip_reset}, 2'h2);
    ev(8'h10);
    chk({mode, power_down_flag, timeout_flag}, {WDO_HALT, 2'h2});
    rd(12'h074, 2'h0, 32'h0, '1);
    rc_clock_enable_bit <= 0;
    @(posedge aclk);
    @(posedge aclk);
    chk(internal_rc_osc_run, 1);
    evt <= 8'h04;
    @(posedge aclk);
    chk(wake, 1);
    evt <= '0;
    @(posedge aclk);
    ev(8'h80);
    chk(power_down_flag, 0);
    // Instruction clock: 398 edges after the clear hold 99 or 100 ticks, so the count is 3.
    cfg.wdt_clk_rc <= 0;
    ev(8'h80);
    repeat (397) @(posedge aclk);
    rd(12'h074, 2'h0, 32'h3, '1);
    ev(8'h10);
    repeat (200) @(posedge aclk);
    rd(12'h074, 2'h0, 32'h0, '1);
    ev(8'h04);
    // Watchdog disabled: 9000 ticks overflow once but never reset the chip.
    cfg <= 7'h31;
    rc_clock_enable_bit <= 1;
    ev(8'h80);
    run_to(0);
    chk(n, 9000);
    rd(12'h074, 2'h0, 32'h19, '1);
    rd(12'h080, 2'h0, 32'h0, 32'h20);
    give_verdict;
  end
endmodule : tb_wdo_top

// ### test/wdo_top_sva.sv
// Port-level assertions for the watchdog top, bound to it.
`timescale 1ns/1ps
module wdo_top_sva
  import wdo_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Core side
  input wire wdo_cfg_t    cfg,
  input wire wdo_evt_t    evt,
  input wire wdo_mode_t   mode,
  input wire logic        sys_osc_run,
  input wire logic        internal_rc_osc_run,
  input wire logic        second_osc_pin,
  input wire logic        wake,
  input wire logic        chip_reset,
  input wire logic        warm_reset,
  input wire logic        charge_pump_output_sel,
  input wire logic        timeout_flag,
  input wire logic        power_down_flag,
  // Register bus
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] ra;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence ctrl_seen;
    s_axi_rvalid && ra == 12'h070 && s_axi_rresp == 2'h0;
  endsequence
  rd_answer_a:
    assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
  rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  pump_sel_a:
    assert property (ctrl_seen |-> charge_pump_output_sel == (s_axi_rdata[1:0] != 2'h2))
    else $error("supply select wrong");
  osc_off_a:
    assert property (ctrl_seen ##0 s_axi_rdata[3:2] == 2'h1 |-> !internal_rc_osc_run)
    else $error("rc osc runs while disabled");
  sleep_osc_a:
    assert property (mode != WDO_RUN |-> !sys_osc_run) else $error("system osc runs asleep");
  stop_halt_a:
    assert property (evt.stop_instr |=> mode == WDO_HALT && power_down_flag && !timeout_flag)
    else $error("stop handling wrong");
  wake_src_a:
    assert property (mode != WDO_RUN && (evt.irq || evt.porta_fall || evt.timer_ovf) |-> wake)
    else $error("no wake");
  chip_once_a:
    assert property (chip_reset |-> cfg.wdt_enable && !warm_reset ##1 !chip_reset)
    else $error("chip reset pulse wrong");
  to_flag_a:
    assert property (chip_reset |-> ##[0:1] timeout_flag) else $error("timeout flag not set");
  warm_sleep_a:
    assert property (warm_reset |-> cfg.wdt_enable && $past(mode) != WDO_RUN)
    else $error("warm reset out of sleep");
  osc_div_a:
    assert property (cfg.ext_rc_mode && $past(cfg.ext_rc_mode, 2) && $past(aresetn, 4)
      && sys_osc_run && $past(sys_osc_run) && $past(sys_osc_run, 2) && $past(sys_osc_run, 3)
      |-> second_osc_pin != $past(second_osc_pin, 2)) else $error("osc pin not clk/4");
endmodule : wdo_top_sva

bind wdo_top wdo_top_sva u_wdo_top_sva (.*);

// ### verilog/wdo_counter.sv
// Prescaler and readable counter of the watchdog.
`timescale 1ns/1ps
module wdo_counter
  import wdo_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [1:0] ratio_sel,
  // Results
  output logic [7:0]      count,
  output logic            overflow
);

  logic [WDO_PRE_W-1:0] pre;
  logic [WDO_PRE_W-1:0] pre_top;

  // Prescale of 2^5..2^8 times 256 counts gives 2^13..2^16 overall.
  assign pre_top = WDO_PRE_W'((1 << (WDO_BASE_SHIFT - 8 + int'(ratio_sel))) - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      pre      <= '0;
      count    <= 8'h00;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (tick) begin
        if (pre >= pre_top) begin
          pre   <= '0;
          count <= 8'(count + 8'h01);
          if (count == 8'hff) begin
            overflow <= 1'b1;
          end
        end else begin
          pre <= WDO_PRE_W'(pre + 1'b1);
        end
      end
    end
  end

endmodule : wdo_counter

// ### verilog/wdo_pkg.sv
// Package of constants and types for the watchdog with oscillator control.
// What this block does
// - Light sleep stops system oscillator; RC oscillator runs when its enable bit is 1.
// - Stop mode with enable bit 0 halts both oscillators unless watchdog enabled.
// - Leave sleep or stop on interrupt, port A fall, watchdog or timer overflow.
// - External RC mode drives system clock divided by four on second oscillator pin.
// - Watchdog counts the internal RC clock or the instruction clock (system/4).
// - Disabled watchdog still counts, reads and clears, but never resets the chip.
// - Supply select bits 1:0: 10 selects regulator, all other codes charge pump.
// - Oscillator enable bits 3:2: 01 disables, 10, 00 and 11 enable.
// - Enable field resets to enabled only with watchdog and RC-clock options both set.
// - Disabled enable field forces RC oscillator off, else the enable bit governs sleep.
// - Counter readout returns the 8-bit count and ignores writes.
// - Overall time-out division is chosen by option from 2^13 to 2^16.
// - Overflow in normal operation gives chip reset and sets the timeout flag.
// - Overflow in sleep or stop gives warm reset of program counter and stack only.
// - Counter cleared by external reset low, clear instruction, or stop instruction.
// - Option picks single clear or both paired clears; one of a pair never clears.
// - On instruction clock the watchdog stops in power-down; external reset or an interrupt, port A fall or timer overflow restarts it.
// - RC oscillator disabled by option or, with watchdog disabled or in light sleep, by software clearing its enable bit.
// - Timeout flag bit 5: cleared by power-up, clear or stop; set by time-out.
// - Power-down flag bit 4: cleared by power-up or clear; set by stop instruction.
package wdo_pkg;

  localparam logic [11:0] WDO_CTRL_OFS     = 12'h01c;
  localparam logic [11:0] WDO_CNT_OFS      = 12'h01d;
  localparam logic [11:0] WDO_STATUS_OFS   = 12'h020;
  localparam int          WDO_CTRL_IDX     = 'h1c;
  localparam int          WDO_CNT_IDX      = 'h1d;
  localparam int          WDO_STATUS_IDX   = 'h20;
  localparam int          WDO_TO_BIT       = 5;
  localparam int          WDO_PDF_BIT      = 4;
  localparam logic [1:0]  WDO_OSC_DISABLE  = 2'h1;
  localparam logic [1:0]  WDO_OSC_ENABLE   = 2'h2;
  localparam logic [1:0]  WDO_PWR_REG      = 2'h2;
  localparam logic [1:0]  WDO_PWR_PUMP     = 2'h1;
  localparam logic [1:0]  WDO_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  WDO_RESP_SLVERR  = 2'h2;
  localparam int          WDO_BASE_SHIFT   = 13;
  localparam int          WDO_PRE_W        = 8;
  localparam logic [1:0]  WDO_INSTR_DIV    = 2'h3;

  typedef enum logic [1:0] {
    WDO_RUN   = 2'b00,
    WDO_IDLE  = 2'b01,
    WDO_HALT  = 2'b10
  } wdo_mode_t;

  typedef struct packed {
    logic       wdt_enable;
    logic       wdt_clk_rc;
    logic       rc_osc_allow;
    logic       paired_clear;
    logic [1:0] ratio_sel;
    logic       ext_rc_mode;
  } wdo_cfg_t;

  typedef struct packed {
    logic       clear_instr;
    logic       clear_first;
    logic       clear_second;
    logic       stop_instr;
    logic       idle_instr;
    logic       irq;
    logic       porta_fall;
    logic       timer_ovf;
  } wdo_evt_t;

endpackage : wdo_pkg

// ### verilog/wdo_top.sv
// Watchdog timer with oscillator control and an AXI4-Lite register slave.
`timescale 1ns/1ps
module wdo_top
  import wdo_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Configuration options and pins
  input  wire wdo_cfg_t    cfg,
  input  wire logic        external_reset_pin_n,
  input  wire logic        power_up,
  input  wire logic        rc_osc_tick,
  input  wire logic        rc_clock_enable_bit,
  // Core events
  input  wire wdo_evt_t    evt,
  // Oscillator and reset outputs
  output logic             sys_osc_run,
  output logic             internal_rc_osc_run,
  output logic             second_osc_pin,
  output logic             wake,
  output logic             chip_reset,
  output logic             warm_reset,
  output logic             charge_pump_output_sel,
  output logic             timeout_flag,
  output logic             power_down_flag,
  output wdo_mode_t        mode,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [1:0]  watchdog_supply_select;
  logic [1:0]  watchdog_osc_enable_field;
  logic        init_pending;
  logic        first_seen;
  logic        second_seen;
  logic [1:0]  sys_div;
  logic        wd_clear;
  logic        wd_tick;
  logic        wd_ovf;
  logic [7:0]  wd_count;
  logic        osc_field_on;
  logic        sleeping;
  logic        wake_src;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [11:0] aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        do_write;
  logic [31:0] next_rdata;
  logic        rd_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= WDO_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[11:2] == 10'(WDO_CTRL_IDX) ||
                       aw_addr[11:2] == 10'(WDO_CNT_IDX) ||
                       aw_addr[11:2] == 10'(WDO_STATUS_IDX)) ? WDO_RESP_OKAY : WDO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    if (s_axi_araddr[11:2] == 10'(WDO_CTRL_IDX)) begin
      next_rdata[3:0] = {watchdog_osc_enable_field, watchdog_supply_select};
    end else if (s_axi_araddr[11:2] == 10'(WDO_CNT_IDX)) begin
      next_rdata[7:0] = wd_count;
    end else if (s_axi_araddr[11:2] == 10'(WDO_STATUS_IDX)) begin
      next_rdata[WDO_TO_BIT]  = timeout_flag;
      next_rdata[WDO_PDF_BIT] = power_down_flag;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= WDO_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? WDO_RESP_OKAY : WDO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // The reset value depends on option inputs, so it is loaded one cycle
  // after release rather than inside the reset branch.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_pending              <= 1'b1;
      watchdog_supply_select    <= WDO_PWR_PUMP;
      watchdog_osc_enable_field <= WDO_OSC_DISABLE;
    end else if (init_pending) begin
      init_pending              <= 1'b0;
      watchdog_osc_enable_field <= (cfg.wdt_enable && cfg.wdt_clk_rc) ?
                                   WDO_OSC_ENABLE : WDO_OSC_DISABLE;
    end else if (do_write && aw_addr[11:2] == 10'(WDO_CTRL_IDX) && w_strb[0]) begin
      watchdog_supply_select    <= w_data[1:0];
      watchdog_osc_enable_field <= w_data[3:2];
    end
  end

  // Only 10 picks the regulator; the caller must have it powered first.
  assign charge_pump_output_sel = (watchdog_supply_select != WDO_PWR_REG);
  assign osc_field_on = (watchdog_osc_enable_field != WDO_OSC_DISABLE);

  // ----------------------------------------------------------------
  // Power modes and oscillators
  // ----------------------------------------------------------------
  assign sleeping = (mode != WDO_RUN);
  assign wake_src = evt.irq || evt.porta_fall || evt.timer_ovf || wd_ovf;

  always_ff @(posedge aclk) begin
    if (!aresetn || !external_reset_pin_n) begin
      mode <= WDO_RUN;
    end else if (sleeping && wake_src) begin
      mode <= WDO_RUN;
    end else if (evt.stop_instr) begin
      mode <= WDO_HALT;
    end else if (evt.idle_instr) begin
      mode <= WDO_IDLE;
    end
  end

  always_comb begin
    sys_osc_run = 1'b1;
    internal_rc_osc_run = 1'b0;
    unique case (mode)
      WDO_RUN: begin
        sys_osc_run = 1'b1;
        internal_rc_osc_run = cfg.rc_osc_allow && osc_field_on;
      end
      WDO_IDLE: begin
        sys_osc_run = 1'b0;
        internal_rc_osc_run = rc_clock_enable_bit;
      end
      WDO_HALT: begin
        sys_osc_run = 1'b0;
        internal_rc_osc_run = rc_clock_enable_bit || cfg.wdt_enable;
      end
      default: begin
        sys_osc_run = 1'b1;
        internal_rc_osc_run = 1'b0;
      end
    endcase
    if (!osc_field_on || !cfg.rc_osc_allow ||
        (!rc_clock_enable_bit && mode == WDO_RUN && !cfg.wdt_enable)) begin
      internal_rc_osc_run = 1'b0;
    end
  end

  assign wake = sleeping && wake_src;

  // ----------------------------------------------------------------
  // Instruction clock divider and second oscillator pin
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div        <= 2'h0;
      second_osc_pin <= 1'b0;
    end else if (sys_osc_run) begin
      sys_div        <= 2'(sys_div + 2'h1);
      second_osc_pin <= cfg.ext_rc_mode && sys_div[1];
    end
  end

  // Instruction clock halts with the system clock, so the watchdog can
  // freeze in power-down until the external reset pin or an interrupt, port A fall or timer overflow wake.
  assign wd_tick = cfg.wdt_clk_rc ? (rc_osc_tick && internal_rc_osc_run)
                                  : (sys_osc_run && sys_div == WDO_INSTR_DIV);

  // ----------------------------------------------------------------
  // Clearing
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || wd_clear) begin
      first_seen  <= 1'b0;
      second_seen <= 1'b0;
    end else begin
      if (evt.clear_first) begin
        first_seen <= 1'b1;
      end
      if (evt.clear_second) begin
        second_seen <= 1'b1;
      end
    end
  end

  always_comb begin
    if (cfg.paired_clear) begin
      wd_clear = (first_seen || evt.clear_first) && (second_seen || evt.clear_second);
    end else begin
      wd_clear = evt.clear_instr;
    end
    wd_clear = wd_clear || !external_reset_pin_n || evt.stop_instr;
  end

  wdo_counter u_counter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (wd_tick),
    .clear     (wd_clear),
    .ratio_sel (cfg.ratio_sel),
    .count     (wd_count),
    .overflow  (wd_ovf)
  );

  // ----------------------------------------------------------------
  // Reset actions and flags
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_reset <= 1'b0;
      warm_reset <= 1'b0;
    end else begin
      chip_reset <= wd_ovf && cfg.wdt_enable && !sleeping;
      warm_reset <= wd_ovf && cfg.wdt_enable && sleeping;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || power_up) begin
      timeout_flag <= 1'b0;
    end else if (wd_ovf && cfg.wdt_enable) begin
      timeout_flag <= 1'b1;
    end else if (wd_clear && !(!external_reset_pin_n && !evt.stop_instr)) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || power_up) begin
      power_down_flag <= 1'b0;
    end else if (evt.stop_instr) begin
      power_down_flag <= 1'b1;
    end else if (evt.clear_instr || (cfg.paired_clear && wd_clear && external_reset_pin_n)) begin
      power_down_flag <= 1'b0;
    end
  end

endmodule : wdo_top
